//--- logic/ocd_pkg.sv
package ocd_pkg;
	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] OCD_HEAD_ADDR   = 32'hF80382BC;
	localparam logic [31:0] OCD_FRAME_ADDR  = 32'hF80382C0;
	localparam logic [31:0] OCD_CTRL_ADDR   = 32'hF80382C4;
	localparam logic [31:0] OCD_NEXT_ADDR   = 32'hF80382C8;
	localparam logic [31:0] OCD_CFG0_ADDR   = 32'hF80382CC;
	localparam logic [31:0] OCD_CFG1_ADDR   = 32'hF80382D0;
	localparam logic [31:0] OCD_STATUS_ADDR = 32'hF8038400;
	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [31:0] OCD_REG_RESET   = 32'h00000000;
	localparam logic [31:0] OCD_CTRL_MASK   = 32'h0000003D;
	localparam logic [31:0] OCD_CFG0_MASK   = 32'h000031F0;
	localparam logic [31:0] OCD_CFG1_MASK   = 32'h0003F3F3;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OCD_FETCH_BIT    = 0;
	localparam int OCD_DMAIEN_BIT   = 2;
	localparam int OCD_DSCRIEN_BIT  = 3;
	localparam int OCD_ADDIEN_BIT   = 4;
	localparam int OCD_DONEIEN_BIT  = 5;
	localparam int OCD_LUMA_BURST_LENGTH_LSB     = 4;
	localparam int OCD_CHROMA_BURST_LENGTH_LSB   = 6;
	localparam int OCD_DEFINED_LENGTH_BURSTS_ONLY_BIT     = 8;
	localparam int OCD_ROTATION_OPTIMISE_DISABLE_BIT   = 12;
	localparam int OCD_ROTATION_LOCK_DISABLE_BIT  = 13;
	localparam int OCD_LUTEN_BIT    = 0;
	localparam int OCD_LUMA_CHROMA_SPACE_ENABLE_BIT    = 1;
	localparam int OCD_RGB_INPUT_FORMAT_LSB  = 4;
	localparam int OCD_LUTMODE_LSB  = 8;
	localparam int OCD_LUMA_CHROMA_INPUT_FORMAT_LSB  = 12;
	// ----------------------------------------------------------------
	// bus burst encodings, descriptor layout and fetch states
	// ----------------------------------------------------------------
	localparam logic [2:0] OCD_BURST_SINGLE  = 3'h0;
	localparam logic [2:0] OCD_BURST_INCR    = 3'h1;
	localparam logic [2:0] burst_four_beat    = 3'h3;
	localparam logic [2:0] burst_eight_beat   = 3'h5;
	localparam logic [2:0] burst_sixteen_beat = 3'h7;
	localparam logic [4:0] OCD_DESC_WORDS    = 5'h03;
	localparam logic [4:0] OCD_BEATS_MAX     = 5'h10;
	localparam logic [31:0] OCD_WORD_BYTES   = 32'h00000004;
	typedef enum logic [2:0] {
		OCD_IDLE  = 3'b000,
		OCD_DREQ  = 3'b001,
		OCD_DDATA = 3'b010,
		OCD_PREQ  = 3'b011,
		OCD_PDATA = 3'b100,
		OCD_DONE  = 3'b101
	} ocd_state_e;
endpackage

//--- logic/ocd_vchan.sv
// Behaviour
// - fetch enable starts or stops descriptor fetching
// - transfer-done irq enabled when bit is 0
// - descriptor-loaded irq enabled when bit is 0
// - queue-add irq enabled when bit is 0
// - list-end irq enabled when bit is 1
// - next descriptor address word readable and writable
// - pixel fetch starts at frame start address
// - luma field 0 reads on one-word room
// - field 1 waits four words, prefers 4-beat
// - field 2 waits eight words, prefers 8-beat
// - field 3 waits sixteen words, prefers 16-beat
// - chroma field uses same four encodings
// - two or three beats use undefined incrementing
// - defined-length-only forbids undefined incrementing bursts
// - rotation optimisation off when bit is 1
// - bus lock on pixel fetches during rotation unless disabled
// - lookup table enable selects pixel decoding
// - colour space bit selects YUV or RGB
// - RGB format codes 0 to 13 decoded
// - lookup depth codes give 1,2,4,8 bpp
// - YUV format codes 0 to 8 decoded
module ocd_vchan #(
	parameter int LEN_W   = 16,
	parameter int SPACE_W = 6
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [31:0]         reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	input  wire logic [SPACE_W-1:0]  fifo_space,
	input  wire logic                rotate_active,
	input  wire logic                bus_grant,
	input  wire logic                bus_rvalid,
	input  wire logic [31:0]         bus_rdata,
	output logic                     bus_req,
	output logic      [31:0]         bus_addr,
	output logic      [2:0]          bus_burst,
	output logic      [4:0]          bus_beats,
	output logic                     bus_lock,
	output logic                     pix_valid,
	output logic      [31:0]         pix_data,
	output logic                     irq_transfer_done,
	output logic                     irq_descriptor_loaded,
	output logic                     irq_queue_add,
	output logic                     irq_list_end,
	output logic                     rotation_optimise,
	output logic                     lut_mode,
	output logic                     yuv_mode,
	output logic      [3:0]          rgb_format,
	output logic      [1:0]          lut_depth,
	output logic      [3:0]          yuv_format,
	output logic      [5:0]          bits_per_pixel
);
	import ocd_pkg::*;

	// ----------------------------------------------------------------
	// burst choice and pixel depth helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] thr_of(input logic [1:0] luma_burst_length);
		unique case (luma_burst_length)
			2'h0: thr_of = 5'h01;
			2'h1: thr_of = 5'h04;
			2'h2: thr_of = 5'h08;
			2'h3: thr_of = 5'h10;
		endcase
	endfunction

	function automatic logic [4:0] beats_of(input logic [LEN_W-1:0] rem, input logic [SPACE_W-1:0] space,
			input logic [1:0] luma_burst_length, input logic defined_length_bursts_only);
		logic [LEN_W:0] lim;
		logic [4:0]     cap;
		lim = (LEN_W+1)'(rem);
		if ((LEN_W+1)'(space) < lim)
			lim = (LEN_W+1)'(space);
		cap = (luma_burst_length == 2'h1) ? 5'h04 : (luma_burst_length == 2'h2) ? 5'h08 : 5'h10;
		if (cap >= 5'h10 && lim >= (LEN_W+1)'(16))
			beats_of = 5'h10;
		else if (cap >= 5'h08 && lim >= (LEN_W+1)'(8))
			beats_of = 5'h08;
		else if (lim >= (LEN_W+1)'(4))
			beats_of = 5'h04;
		else if (lim >= (LEN_W+1)'(2) && !defined_length_bursts_only)
			beats_of = lim[4:0];
		else
			beats_of = 5'h01;
	endfunction

	function automatic logic [2:0] code_of(input logic [4:0] beats);
		unique case (beats)
			5'h01:   code_of = OCD_BURST_SINGLE;
			5'h04:   code_of = burst_four_beat;
			5'h08:   code_of = burst_eight_beat;
			5'h10:   code_of = burst_sixteen_beat;
			default: code_of = OCD_BURST_INCR;
		endcase
	endfunction

	function automatic logic [5:0] bpp_of(input logic luten, input logic luma_chroma_space_enable, input logic [3:0] rgb,
			input logic [1:0] lut, input logic [3:0] yuv);
		logic [5:0] r;
		r = 6'h00;
		if (luten) begin
			unique case (lut)
				2'h0: r = 6'h01;
				2'h1: r = 6'h02;
				2'h2: r = 6'h04;
				2'h3: r = 6'h08;
			endcase
		end else if (luma_chroma_space_enable) begin
			unique case (yuv)
				4'h0:                      r = 6'h20;
				4'h1, 4'h2, 4'h3, 4'h4:    r = 6'h10;
				4'h5, 4'h6:                r = 6'h10;
				4'h7, 4'h8:                r = 6'h0C;
				default:                   r = 6'h00;
			endcase
		end else begin
			unique case (rgb)
				4'h0:                      r = 6'h0C;
				4'h1, 4'h2, 4'h3, 4'h4:    r = 6'h10;
				4'h5, 4'h6:                r = 6'h12;
				4'h7, 4'h8:                r = 6'h13;
				4'h9, 4'hA:                r = 6'h18;
				4'hB:                      r = 6'h19;
				4'hC, 4'hD:                r = 6'h20;
				default:                   r = 6'h00;
			endcase
		end
		bpp_of = r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ocd_state_e        state_q, state_d;
	logic [31:0]       head_q, head_d;
	logic [31:0]       frame_q, frame_d;
	logic [31:0]       ctrl_q, ctrl_d;
	logic [31:0]       next_q, next_d;
	logic [31:0]       cfg0_q, cfg0_d;
	logic [31:0]       cfg1_q, cfg1_d;
	logic [31:0]       dptr_q, dptr_d;
	logic [31:0]       cur_q, cur_d;
	logic [LEN_W-1:0]  rem_q, rem_d;
	logic [4:0]        left_q, left_d;
	logic              pend_q, pend_d;
	logic              first_q, first_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              req_q, req_d;
	logic [31:0]       baddr_q, baddr_d;
	logic [2:0]        burst_q, burst_d;
	logic [4:0]        beats_q, beats_d;
	logic              lock_q, lock_d;
	logic              pv_q, pv_d;
	logic [31:0]       pd_q, pd_d;
	logic              ev_done_q, ev_done_d;
	logic              ev_load_q, ev_load_d;
	logic              ev_add_q, ev_add_d;
	logic              ev_end_q, ev_end_d;
	logic              irq_dn_q, irq_ld_q, irq_ad_q, irq_en_q;
	logic [5:0]        bpp_q;
	logic              rot_opt_q;

	logic [1:0]        luma_burst_length_sel;
	logic              defined_length_bursts_only;
	logic [4:0]        thr;
	logic [4:0]        nb;
	logic [LEN_W-1:0]  desc_len;
	logic [1:0]        widx;

	assign defined_length_bursts_only     = cfg0_q[OCD_DEFINED_LENGTH_BURSTS_ONLY_BIT];
	assign luma_burst_length_sel = cfg1_q[OCD_LUMA_CHROMA_SPACE_ENABLE_BIT] ? cfg0_q[OCD_CHROMA_BURST_LENGTH_LSB +: 2] : cfg0_q[OCD_LUMA_BURST_LENGTH_LSB +: 2];
	assign thr      = thr_of(luma_burst_length_sel);
	assign desc_len = bus_rdata[LEN_W-1:0];
	assign widx     = 2'(OCD_DESC_WORDS - rem_q[4:0]);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_d   = state_q;
		head_d    = head_q;
		frame_d   = frame_q;
		ctrl_d    = ctrl_q;
		next_d    = next_q;
		cfg0_d    = cfg0_q;
		cfg1_d    = cfg1_q;
		dptr_d    = dptr_q;
		cur_d     = cur_q;
		rem_d     = rem_q;
		left_d    = left_q;
		pend_d    = pend_q;
		first_d   = first_q;
		req_d     = req_q;
		baddr_d   = baddr_q;
		burst_d   = burst_q;
		beats_d   = beats_q;
		pv_d      = 1'b0;
		pd_d      = pd_q;
		ev_done_d = 1'b0;
		ev_load_d = 1'b0;
		ev_add_d  = 1'b0;
		ev_end_d  = 1'b0;
		nb        = 5'h01;
		rdata_d   = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				OCD_HEAD_ADDR:   rdata_d = head_q;
				OCD_FRAME_ADDR:  rdata_d = frame_q;
				OCD_CTRL_ADDR:   rdata_d = ctrl_q & OCD_CTRL_MASK;
				OCD_NEXT_ADDR:   rdata_d = next_q;
				OCD_CFG0_ADDR:   rdata_d = cfg0_q & OCD_CFG0_MASK;
				OCD_CFG1_ADDR:   rdata_d = cfg1_q & OCD_CFG1_MASK;
				OCD_STATUS_ADDR: rdata_d = {pend_q, 12'h000, state_q, rem_q};
				default:         rdata_d = 32'h00000000;
			endcase
		end
		// software writes, later hardware updates win
		if (reg_wr) begin
			unique case (reg_addr)
				OCD_HEAD_ADDR: begin
					head_d   = reg_wdata;
					pend_d   = 1'b1;
					ev_add_d = 1'b1;
				end
				OCD_FRAME_ADDR: frame_d = reg_wdata;
				OCD_CTRL_ADDR:  ctrl_d  = reg_wdata & OCD_CTRL_MASK;
				OCD_NEXT_ADDR:  next_d  = reg_wdata;
				OCD_CFG0_ADDR:  cfg0_d  = reg_wdata & OCD_CFG0_MASK;
				OCD_CFG1_ADDR:  cfg1_d  = reg_wdata & OCD_CFG1_MASK;
				default: ;
			endcase
		end
		unique case (state_q)
			OCD_IDLE: begin
				if (ctrl_q[OCD_FETCH_BIT] && pend_q) begin
					dptr_d  = head_q;
					rem_d   = LEN_W'(OCD_DESC_WORDS);
					state_d = OCD_DREQ;
					if (!(reg_wr && reg_addr == OCD_HEAD_ADDR))
						pend_d = 1'b0;
				end
			end
			OCD_DREQ: begin
				if (!req_q) begin
					nb      = beats_of(rem_q, SPACE_W'(OCD_BEATS_MAX), 2'h0, defined_length_bursts_only);
					req_d   = 1'b1;
					baddr_d = dptr_q;
					beats_d = nb;
					burst_d = code_of(nb);
					left_d  = nb;
				end else if (bus_grant) begin
					req_d   = 1'b0;
					state_d = OCD_DDATA;
				end
			end
			OCD_DDATA: begin
				if (bus_rvalid) begin
					unique case (widx)
						2'h0:    frame_d = bus_rdata;
						2'h1:    cur_d   = {{(32-LEN_W){1'b0}}, desc_len};
						default: next_d  = bus_rdata;
					endcase
					dptr_d = dptr_q + OCD_WORD_BYTES;
					rem_d  = rem_q - 1'b1;
					left_d = left_q - 1'b1;
					if (rem_q == LEN_W'(1)) begin
						ev_load_d = 1'b1;
						rem_d     = cur_q[LEN_W-1:0];
						cur_d     = frame_q;
						first_d   = 1'b1;
						state_d   = (cur_q[LEN_W-1:0] == '0) ? OCD_DONE : OCD_PREQ;
					end else if (left_q == 5'h01) begin
						state_d = OCD_DREQ;
					end
				end
			end
			OCD_PREQ: begin
				if (!req_q) begin
					if (5'(fifo_space) >= thr || fifo_space >= SPACE_W'(OCD_BEATS_MAX)) begin
						nb      = beats_of(rem_q, fifo_space, luma_burst_length_sel, defined_length_bursts_only);
						req_d   = 1'b1;
						baddr_d = cur_q;
						beats_d = nb;
						burst_d = code_of(nb);
						left_d  = nb;
					end
				end else if (bus_grant) begin
					req_d   = 1'b0;
					first_d = 1'b0;
					state_d = OCD_PDATA;
				end
			end
			OCD_PDATA: begin
				if (bus_rvalid) begin
					pv_d   = 1'b1;
					pd_d   = bus_rdata;
					cur_d  = cur_q + OCD_WORD_BYTES;
					rem_d  = rem_q - 1'b1;
					left_d = left_q - 1'b1;
					if (rem_q == LEN_W'(1))
						state_d = OCD_DONE;
					else if (left_q == 5'h01)
						state_d = OCD_PREQ;
				end
			end
			OCD_DONE: begin
				ev_done_d = 1'b1;
				if (next_q == 32'h00000000) begin
					ev_end_d = 1'b1;
					state_d  = OCD_IDLE;
				end else if (ctrl_q[OCD_FETCH_BIT]) begin
					dptr_d  = next_q;
					rem_d   = LEN_W'(OCD_DESC_WORDS);
					state_d = OCD_DREQ;
				end else begin
					head_d  = next_q;
					pend_d  = 1'b1;
					state_d = OCD_IDLE;
				end
			end
			default: state_d = OCD_IDLE;
		endcase
		// lock only while pixel traffic of a rotation runs
		lock_d = rotate_active && !cfg0_q[OCD_ROTATION_LOCK_DISABLE_BIT] && (state_d == OCD_PREQ || state_d == OCD_PDATA);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q   <= OCD_IDLE;
			head_q    <= OCD_REG_RESET;
			frame_q   <= OCD_REG_RESET;
			ctrl_q    <= OCD_REG_RESET;
			next_q    <= OCD_REG_RESET;
			cfg0_q    <= OCD_REG_RESET;
			cfg1_q    <= OCD_REG_RESET;
			dptr_q    <= 32'h00000000;
			cur_q     <= 32'h00000000;
			rem_q     <= '0;
			left_q    <= 5'h00;
			pend_q    <= 1'b0;
			first_q   <= 1'b0;
			rdata_q   <= 32'h00000000;
			req_q     <= 1'b0;
			baddr_q   <= 32'h00000000;
			burst_q   <= 3'h0;
			beats_q   <= 5'h00;
			lock_q    <= 1'b0;
			pv_q      <= 1'b0;
			pd_q      <= 32'h00000000;
			ev_done_q <= 1'b0;
			ev_load_q <= 1'b0;
			ev_add_q  <= 1'b0;
			ev_end_q  <= 1'b0;
			irq_dn_q  <= 1'b0;
			irq_ld_q  <= 1'b0;
			irq_ad_q  <= 1'b0;
			irq_en_q  <= 1'b0;
			bpp_q     <= 6'h00;
			rot_opt_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			head_q    <= head_d;
			frame_q   <= frame_d;
			ctrl_q    <= ctrl_d;
			next_q    <= next_d;
			cfg0_q    <= cfg0_d;
			cfg1_q    <= cfg1_d;
			dptr_q    <= dptr_d;
			cur_q     <= cur_d;
			rem_q     <= rem_d;
			left_q    <= left_d;
			pend_q    <= pend_d;
			first_q   <= first_d;
			rdata_q   <= rdata_d;
			req_q     <= req_d;
			baddr_q   <= baddr_d;
			burst_q   <= burst_d;
			beats_q   <= beats_d;
			lock_q    <= lock_d;
			pv_q      <= pv_d;
			pd_q      <= pd_d;
			ev_done_q <= ev_done_d;
			ev_load_q <= ev_load_d;
			ev_add_q  <= ev_add_d;
			ev_end_q  <= ev_end_d;
			irq_dn_q  <= ev_done_q && !ctrl_q[OCD_DMAIEN_BIT];
			irq_ld_q  <= ev_load_q && !ctrl_q[OCD_DSCRIEN_BIT];
			irq_ad_q  <= ev_add_q && !ctrl_q[OCD_ADDIEN_BIT];
			irq_en_q  <= ev_end_q && ctrl_q[OCD_DONEIEN_BIT];
			bpp_q     <= bpp_of(cfg1_q[OCD_LUTEN_BIT], cfg1_q[OCD_LUMA_CHROMA_SPACE_ENABLE_BIT], cfg1_q[OCD_RGB_INPUT_FORMAT_LSB +: 4],
				cfg1_q[OCD_LUTMODE_LSB +: 2], cfg1_q[OCD_LUMA_CHROMA_INPUT_FORMAT_LSB +: 4]);
			rot_opt_q <= !cfg0_d[OCD_ROTATION_OPTIMISE_DISABLE_BIT];
		end
	end

	assign reg_rdata             = rdata_q;
	assign bus_req               = req_q;
	assign bus_addr              = baddr_q;
	assign bus_burst             = burst_q;
	assign bus_beats             = beats_q;
	assign bus_lock              = lock_q;
	assign pix_valid             = pv_q;
	assign pix_data              = pd_q;
	assign irq_transfer_done     = irq_dn_q;
	assign irq_descriptor_loaded = irq_ld_q;
	assign irq_queue_add         = irq_ad_q;
	assign irq_list_end          = irq_en_q;
	assign rotation_optimise     = rot_opt_q;
	assign lut_mode              = cfg1_q[OCD_LUTEN_BIT];
	assign yuv_mode              = cfg1_q[OCD_LUMA_CHROMA_SPACE_ENABLE_BIT];
	assign rgb_format            = cfg1_q[OCD_RGB_INPUT_FORMAT_LSB +: 4];
	assign lut_depth             = cfg1_q[OCD_LUTMODE_LSB +: 2];
	assign yuv_format            = cfg1_q[OCD_LUMA_CHROMA_INPUT_FORMAT_LSB +: 4];
	assign bits_per_pixel        = bpp_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence done_evt_s;
		ev_done_q ##1 1'b1;
	endsequence

	fetch_off_idle_a: assert property (@(posedge clk) disable iff (reset)
		state_q == OCD_IDLE && !ctrl_q[OCD_FETCH_BIT] |=> state_q == OCD_IDLE)
		else $error("descriptor fetch started while disabled");
	done_irq_pol_a: assert property (@(posedge clk) disable iff (reset)
		done_evt_s |-> irq_transfer_done == !$past(ctrl_q[OCD_DMAIEN_BIT]))
		else $error("transfer done irq polarity wrong");
	load_irq_pol_a: assert property (@(posedge clk) disable iff (reset)
		ev_load_q |=> irq_descriptor_loaded == !$past(ctrl_q[OCD_DSCRIEN_BIT]))
		else $error("descriptor loaded irq polarity wrong");
	add_irq_pol_a: assert property (@(posedge clk) disable iff (reset)
		reg_wr && reg_addr == OCD_HEAD_ADDR && !ctrl_q[OCD_ADDIEN_BIT] && !(reg_wr && reg_addr == OCD_CTRL_ADDR)
		|-> ##2 irq_queue_add)
		else $error("queue add irq missing");
	end_irq_pol_a: assert property (@(posedge clk) disable iff (reset)
		irq_list_end |-> $past(ev_end_q) && $past(ctrl_q[OCD_DONEIEN_BIT]))
		else $error("list end irq without enable");
	next_word_rw_a: assert property (@(posedge clk) disable iff (reset)
		reg_wr && reg_addr == OCD_NEXT_ADDR && state_q == OCD_IDLE |=> next_q == $past(reg_wdata))
		else $error("next descriptor word not stored");
	pixel_start_addr_a: assert property (@(posedge clk) disable iff (reset)
		state_q == OCD_PREQ && req_q && first_q |-> baddr_q == frame_q)
		else $error("pixel fetch not at frame start");
	fifo_room_wait_a: assert property (@(posedge clk) disable iff (reset)
		state_q == OCD_PREQ && !req_q ##1 req_q |-> 5'($past(fifo_space)) >= $past(thr) || $past(fifo_space) >= 16)
		else $error("burst started without fifo room");
	defined_only_a: assert property (@(posedge clk) disable iff (reset)
		$rose(req_q) && $past(defined_length_bursts_only) |-> burst_q != OCD_BURST_INCR)
		else $error("undefined burst with defined-only set");
	rotation_lock_a: assert property (@(posedge clk) disable iff (reset)
		bus_lock |-> $past(rotate_active) && !$past(cfg0_q[OCD_ROTATION_LOCK_DISABLE_BIT]))
		else $error("lock asserted though disabled");
	reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
		reg_rd && reg_addr == OCD_CTRL_ADDR |=> (reg_rdata & ~OCD_CTRL_MASK) == 32'h00000000)
		else $error("reserved control bits read nonzero");
	done_then_idle_a: assert property (@(posedge clk) disable iff (reset)
		done_evt_s |-> state_q != OCD_DONE)
		else $error("done state held too long");
endmodule

//--- testbench/ocd_mem_model.sv
module ocd_mem_model (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        slow,
	input  wire logic        bus_req,
	input  wire logic [31:0] bus_addr,
	input  wire logic [4:0]  bus_beats,
	output logic             bus_grant,
	output logic             bus_rvalid,
	output logic      [31:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:127];
	logic [31:0] addr_q;
	logic [4:0]  left_q;
	logic        pace_q;
	// --------
	// grant a request, then return its beats; idle data toggles
	// --------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus_grant  <= 1'b0;
			bus_rvalid <= 1'b0;
			bus_rdata  <= 32'h00000000;
			addr_q     <= 32'h00000000;
			left_q     <= 5'h00;
			pace_q     <= 1'b0;
		end else begin
			pace_q     <= ~pace_q;
			bus_grant  <= 1'b0;
			bus_rvalid <= 1'b0;
			bus_rdata  <= ~bus_rdata;
			if (!(slow && pace_q)) begin
				if (left_q != 5'h00) begin
					bus_rvalid <= 1'b1;
					bus_rdata  <= mem[addr_q[8:2]];
					addr_q     <= addr_q + 32'h00000004;
					left_q     <= left_q - 5'h01;
				end else if (bus_req && !bus_grant) begin
					bus_grant <= 1'b1;
					addr_q    <= bus_addr;
					left_q    <= bus_beats;
				end
			end
		end
	end
endmodule

//--- testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ocd_pkg::*;
	logic        clk, reset, reg_wr, reg_rd, rotate_active, slow, bus_grant, bus_rvalid, bus_req, bus_lock, pix_valid;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, bus_rdata, bus_addr, pix_data, rs, frame;
	logic [5:0]  fifo_space, bits_per_pixel;
	logic [2:0]  bus_burst;
	logic [4:0]  bus_beats;
	logic [3:0]  rgb_format, yuv_format;
	logic [1:0]  lut_depth, bl;
	logic        irq_transfer_done, irq_descriptor_loaded, irq_queue_add, irq_list_end;
	logic        rotation_optimise, lut_mode, yuv_mode, dl, rotation_lock_disable;
	logic [7:0]  exp8;
	int          num_errors, tests_run, len, issued, np, ng;
	int          ev [4];
	ocd_vchan dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_space(fifo_space), .rotate_active(rotate_active),
		.bus_grant(bus_grant), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata), .bus_req(bus_req),
		.bus_addr(bus_addr), .bus_burst(bus_burst), .bus_beats(bus_beats), .bus_lock(bus_lock),
		.pix_valid(pix_valid), .pix_data(pix_data), .irq_transfer_done(irq_transfer_done),
		.irq_descriptor_loaded(irq_descriptor_loaded), .irq_queue_add(irq_queue_add),
		.irq_list_end(irq_list_end), .rotation_optimise(rotation_optimise), .lut_mode(lut_mode),
		.yuv_mode(yuv_mode), .rgb_format(rgb_format), .lut_depth(lut_depth), .yuv_format(yuv_format),
		.bits_per_pixel(bits_per_pixel));
	ocd_mem_model mm (.clk(clk), .reset(reset), .slow(slow), .bus_req(bus_req), .bus_addr(bus_addr),
		.bus_beats(bus_beats), .bus_grant(bus_grant), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// --------
	// helpers
	// --------
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [5:0] bpp(input logic [31:0] c);
		if (c[0]) return 6'h01 << c[9:8];
		if (c[1]) begin
			case (c[15:12])
				4'h0: return 6'h20;
				4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: return 6'h10;
				4'h7, 4'h8: return 6'h0C;
				default: return 6'h00;
			endcase
		end
		case (c[7:4])
			4'h0: return 6'h0C;
			4'h1, 4'h2, 4'h3, 4'h4: return 6'h10;
			4'h5, 4'h6: return 6'h12;
			4'h7, 4'h8: return 6'h13;
			4'h9, 4'hA: return 6'h18;
			4'hB: return 6'h19;
			4'hC, 4'hD: return 6'h20;
			default: return 6'h00;
		endcase
	endfunction
	function automatic logic [7:0] bexp(input logic [1:0] b, input logic d, input int m);
		if ((b == 2'h0 || b == 2'h3) && m >= 16) return {burst_sixteen_beat, 5'h10};
		if (b != 2'h1 && m >= 8) return {burst_eight_beat, 5'h08};
		if (m >= 4) return {burst_four_beat, 5'h04};
		if (m >= 2 && !d) return {OCD_BURST_INCR, 5'(m)};
		return {OCD_BURST_SINGLE, 5'h01};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// --------
	// bus and pixel monitor
	// --------
	always @(posedge clk) begin
		if (!reset) begin
			if (irq_transfer_done === 1'b1) ev[0]++;
			if (irq_descriptor_loaded === 1'b1) ev[1]++;
			if (irq_queue_add === 1'b1) ev[2]++;
			if (irq_list_end === 1'b1) ev[3]++;
			if (pix_valid === 1'b1) begin
				chk(pix_data, mm.mem[frame[8:2] + np]);
				np++;
			end
			if (bus_req === 1'b1 && bus_grant === 1'b1) begin
				if (ng < (dl ? 3 : 1)) begin
					chk({bus_burst, bus_beats}, dl ? {OCD_BURST_SINGLE, 5'h01} : {OCD_BURST_INCR, 5'h03});
					chk(bus_addr, 32'h00000010 + 4 * ng);
					chk(bus_lock, 1'b0);
				end else begin
					exp8 = bexp(bl, dl, (len - issued < fifo_space) ? len - issued : fifo_space);
					chk({bus_burst, bus_beats}, exp8);
					chk(bus_addr, frame + 4 * issued);
					chk(bus_lock, rotate_active & ~rotation_lock_disable);
					issued += bus_beats;
				end
				ng++;
			end
		end
	end
	task automatic xfer(input logic [31:0] c0, input int n);
		logic [31:0] ct, c1;
		int          thr, k;
		ct = (rnd() & 32'h0000003C) | 32'h00000001;
		c1 = rnd() & 32'h00000002;
		c0 = c0 & OCD_CFG0_MASK;
		bl = c1[1] ? c0[7:6] : c0[5:4];
		dl = c0[8];
		rotation_lock_disable = c0[13];
		len = n;
		frame = 32'h00000040;
		mm.mem[4] = frame;
		mm.mem[5] = n;
		mm.mem[6] = 32'h00000000;
		for (int i = 0; i < n; i++) mm.mem[16 + i] = rnd();
		thr = (bl == 2'h0) ? 1 : 2 << bl;
		wr(OCD_CFG0_ADDR, c0);
		wr(OCD_CFG1_ADDR, c1);
		wr(OCD_CTRL_ADDR, ct);
		fifo_space <= 6'(thr + rnd() % (64 - thr));
		rotate_active <= ^rnd();
		slow <= ^rnd();
		ev = '{4{0}};
		np = 0;
		issued = 0;
		ng = 0;
		wr(OCD_HEAD_ADDR, 32'h00000010);
		for (k = 0; k < 4000 && np < len; k++) @(posedge clk);
		if (np < len) begin
			num_errors++;
			report_and_stop();
		end
		repeat (12) @(posedge clk);
		chk(issued, len);
		chk(ev[0], 32'(!ct[2]));
		chk(ev[1], 32'(!ct[3]));
		chk(ev[2], 32'(!ct[4]));
		chk(ev[3], 32'(ct[5]));
		chk(rotation_optimise, !c0[12]);
	endtask
	// --------
	// main sequence
	// --------
	logic [31:0] a4 [4];
	logic [31:0] m4 [4];
	logic [31:0] c;
	initial begin
		rs = 32'h0001619D;
		num_errors = 0;
		tests_run = 0;
		{reg_wr, reg_rd, rotate_active, slow, reg_addr, reg_wdata, fifo_space} = '0;
		a4 = '{OCD_CTRL_ADDR, OCD_NEXT_ADDR, OCD_CFG0_ADDR, OCD_CFG1_ADDR};
		m4 = '{OCD_CTRL_MASK, 32'hFFFFFFFF, OCD_CFG0_MASK, OCD_CFG1_MASK};
		reset = 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) rd(a4[i], OCD_REG_RESET);
		for (int j = 0; j < 16; j++) begin
			c = rnd() & ((j % 4 == 0) ? 32'hFFFFFFFE : 32'hFFFFFFFF);
			wr(a4[j % 4], c);
			rd(a4[j % 4], c & m4[j % 4]);
		end
		wr(32'hF80382D4, rnd());
		rd(32'hF80382D4, 32'h00000000);
		for (int i = 0; i < 36; i++) begin
			c = (i < 16) ? i << 4 : (i < 20) ? 32'h1 | ((i - 16) << 8) : 32'h2 | ((i - 20) << 12);
			c = c | (rnd() & 32'hFFFF0C0C);
			wr(OCD_CFG1_ADDR, c);
			rd(OCD_CFG1_ADDR, c & OCD_CFG1_MASK);
			chk(bits_per_pixel, bpp(c));
			chk({lut_mode, yuv_mode, rgb_format, lut_depth, yuv_format}, {c[0], c[1], c[7:4], c[9:8], c[15:12]});
		end
		xfer(32'h00000130, 3);
		xfer(32'h00000030, 16);
		xfer(32'h00000000, 2);
		for (int i = 0; i < 10; i++) xfer(rnd(), 1 + rnd() % 40);
		wr(OCD_CTRL_ADDR, 32'h00000000);
		wr(OCD_HEAD_ADDR, 32'h00000010);
		repeat (40) begin
			@(negedge clk);
			chk(bus_req, 1'b0);
		end
		report_and_stop();
	end
endmodule
